// File: arb_top.sv
/*
 * Converter result sequencer: interrupt point counting, scan restart, result
 * buffer placement for buffered and DMA modes, done flag and op amp pin claim.
 * Assumes the converter pulses conv_start_i/conv_done_i synchronous to mclk_i
 * (25 MHz) and honours conv_ready_o before presenting a result.
 */
`timescale 1ns/1ps
`default_nettype none
`include "arb_regs.svh"

module arb_top #(
    parameter int DMA_AW = `ARB_DMA_AW,
    parameter int FIFO_DEPTH = `ARB_FIFO_DEPTH
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [`ARB_SMPI_W-1:0] samples_per_irq_i,
    input wire logic scan_inputs_enable_i,
    input wire logic [15:0] scan_select_low_i,
    input wire logic [15:0] scan_select_high_i,
    input wire logic conv_dma_enable_i,
    input wire logic irq_enable_i,
    input wire logic opamp2_enable_i,
    input wire arb_pkg::arb_ch_t input_mux_alt_set_i,
    input wire logic conv_start_i,
    input wire logic conv_done_i,
    input wire arb_pkg::arb_data_t conv_result_i,
    input wire logic done_clear_i,
    input wire logic irq_flag_clear_i,
    input wire logic buf_freeze_i,
    input wire logic [`ARB_BUF_W-1:0] rd_index_i,
    output var logic conv_ready_o,
    output var arb_pkg::arb_ch_t conv_channel_o,
    output var logic conv_done_flag_o,
    output var logic irq_flag_o,
    output var logic irq_o,
    output var arb_pkg::arb_data_t rd_data_o,
    output var logic [`ARB_BUF_W-1:0] buf_ptr_o,
    output var logic dma_req_o,
    output var logic [DMA_AW-1:0] dma_addr_o,
    output var logic mux_conflict_o,
    output var logic [`ARB_OPAMP_PIN_CNT-1:0] opamp_pins_o
);
    import arb_pkg::*;

    arb_data_t buf_r [`ARB_NUM_BUFS];
    logic [`ARB_SMPI_W-1:0] cnt_r;
    logic fifo_valid;
    arb_data_t fifo_data;

    // results pass a small FIFO so a burst from the converter survives a short freeze
    arb_fifo #(
        .W(`ARB_DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(mclk_i),
        .rst_i(rst_i),
        .in_valid_i(conv_done_i),
        .in_data_i(conv_result_i),
        .in_ready_o(conv_ready_o),
        .out_valid_o(fifo_valid),
        .out_data_o(fifo_data),
        .out_ready_i(!buf_freeze_i)
    );

    // decode of the completion event and the sample count point
    wire arb_mode_e mode = conv_dma_enable_i ? ARB_MODE_DMA : ARB_MODE_BUFFERED;
    wire is_dma = mode == ARB_MODE_DMA;
    wire take = fifo_valid & !buf_freeze_i;
    wire irq_point = take && (cnt_r == samples_per_irq_i);
    wire [`ARB_SMPI_W-1:0] cnt_nxt = irq_point ? '0 : cnt_r + `ARB_SMPI_W'(1);
    // placement uses the running pointer, or buffer zero in DMA mode; the channel number never enters it
    wire [`ARB_BUF_W-1:0] wr_idx = is_dma ? '0 : buf_ptr_o;
    wire [`ARB_BUF_W-1:0] ptr_nxt = (is_dma || irq_point) ? '0 : buf_ptr_o + `ARB_BUF_W'(1);
    wire dma_adv = take && is_dma && irq_point;
    wire [DMA_AW-1:0] dma_addr_nxt = dma_addr_o + DMA_AW'(1);

    // inputs claimed by op amp two are masked out of the scan list
    wire [`ARB_NUM_CH-1:0] claim_m = opamp2_enable_i ? `ARB_OPAMP2_PINS : '0;
    wire [`ARB_NUM_CH-1:0] scan_mask = {scan_select_high_i, scan_select_low_i} & ~claim_m;
    wire alt_conflict = opamp2_enable_i && (input_mux_alt_set_i < `ARB_MUX_FIRST_FREE);

    // hardware set beats any clear arriving in the same cycle
    wire done_nxt = conv_done_i ? 1'b1 : (conv_start_i || done_clear_i) ? 1'b0 : conv_done_flag_o;
    wire irq_flag_nxt = irq_point ? 1'b1 : irq_flag_clear_i ? 1'b0 : irq_flag_o;

    arb_scan u_scan (
        .clk_i(mclk_i),
        .rst_i(rst_i),
        .enable_i(scan_inputs_enable_i),
        .select_i(scan_mask),
        .manual_ch_i(input_mux_alt_set_i),
        .restart_i(irq_point && scan_inputs_enable_i),
        .advance_i(take),
        .channel_o(conv_channel_o)
    );

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            cnt_r <= '0;
            buf_ptr_o <= '0;
            dma_addr_o <= '0;
            dma_req_o <= 1'b0;
        end else begin
            if (take) begin
                cnt_r <= cnt_nxt;
                buf_ptr_o <= ptr_nxt;
            end
            if (dma_adv) begin
                dma_addr_o <= dma_addr_nxt;
            end
            // the reader has one conversion time to take buffer zero before it is overwritten
            dma_req_o <= take && is_dma;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            conv_done_flag_o <= 1'b0;
            irq_flag_o <= 1'b0;
            irq_o <= 1'b0;
            mux_conflict_o <= 1'b0;
            opamp_pins_o <= '0;
        end else begin
            conv_done_flag_o <= done_nxt;
            irq_flag_o <= irq_flag_nxt;
            irq_o <= irq_point && irq_enable_i;
            mux_conflict_o <= alt_conflict;
            opamp_pins_o <= claim_m[`ARB_OPAMP_PIN_CNT-1:0];
        end
    end

    for (genvar g = 0; g < `ARB_NUM_BUFS; g++) begin : g_buf
        wire hit = take && (wr_idx == `ARB_BUF_W'(g));
        always_ff @(posedge mclk_i) begin
            if (rst_i) begin
                buf_r[g] <= '0;
            end else if (hit) begin
                buf_r[g] <= fifo_data;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            rd_data_o <= '0;
        end else begin
            rd_data_o <= buf_r[rd_index_i];
        end
    end

    // checks
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);

    wire [`ARB_NUM_CH-1:0] low_onehot = scan_mask & (~scan_mask + `ARB_NUM_CH'(1));

    a_irq_flag_set: assert property (
        irq_point |=> irq_flag_o
    ) else $error("interrupt flag not set at count point");

    a_irq_gate_off: assert property (
        (irq_point && !irq_enable_i) |=> !irq_o
    ) else $error("interrupt raised while disabled");

    a_irq_only_point: assert property (
        irq_o |-> $past(irq_point) && $past(irq_enable_i)
    ) else $error("interrupt pulse without count point");

    a_scan_restart_first: assert property (
        (irq_point && scan_inputs_enable_i && (scan_mask != '0))
            |=> ((`ARB_NUM_CH'(1) << conv_channel_o) == $past(low_onehot))
    ) else $error("scan did not restart at first listed channel");

    a_ptr_reset_point: assert property (
        (irq_point && !is_dma) |=> (buf_ptr_o == '0)
    ) else $error("buffer pointer not reset at count point");

    a_dma_buf_zero: assert property (
        (take && is_dma) |=> (buf_r[0] == $past(fifo_data)) && dma_req_o
    ) else $error("DMA result not placed in buffer zero");

    a_dma_addr_step: assert property (
        dma_adv |=> (dma_addr_o == $past(dma_addr_o) + DMA_AW'(1))
    ) else $error("DMA address did not advance at count point");

    a_dma_addr_hold: assert property (
        !dma_adv |=> $stable(dma_addr_o)
    ) else $error("DMA address moved off the count point");

    a_seq_ptr_step: assert property (
        (take && !is_dma && !irq_point) |=> (buf_ptr_o == $past(buf_ptr_o) + `ARB_BUF_W'(1))
    ) else $error("buffer pointer did not step in sequence");

    a_seq_buf_write: assert property (
        (take && !is_dma) |=> (buf_r[$past(buf_ptr_o)] == $past(fifo_data))
    ) else $error("result not stored at sequence position");

    a_done_set_hold: assert property (
        conv_done_i |=> conv_done_flag_o
    ) else $error("done flag not set on completion");

    a_done_start_clear: assert property (
        (conv_start_i && !conv_done_i) |=> !conv_done_flag_o
    ) else $error("done flag not cleared at conversion start");

    a_done_stays_set: assert property (
        (conv_done_flag_o && !conv_start_i && !done_clear_i) |=> conv_done_flag_o
    ) else $error("done flag dropped without a start");

    a_opamp_conflict: assert property (
        (opamp2_enable_i && input_mux_alt_set_i < `ARB_MUX_FIRST_FREE) |=> mux_conflict_o && (opamp_pins_o == '1)
    ) else $error("op amp pin claim not reported");

    a_count_restart: assert property (
        irq_point |=> (cnt_r == '0)
    ) else $error("sample count not restarted at count point");

    // further checks on flags, scan, pointers, DMA, op amp claim and sample count
    a_irq_flag_hold: assert property (
        (irq_flag_o && !irq_point && !irq_flag_clear_i) |=> irq_flag_o
    ) else $error("interrupt flag dropped without a clear");

    a_irq_flag_clear: assert property (
        (irq_flag_clear_i && !irq_point) |=> !irq_flag_o
    ) else $error("interrupt flag not cleared");

    a_irq_pulse_on: assert property (
        (irq_point && irq_enable_i) |=> irq_o
    ) else $error("interrupt not raised while enabled");

    a_scan_manual_off: assert property (
        !scan_inputs_enable_i |=> (conv_channel_o == $past(input_mux_alt_set_i))
    ) else $error("manual channel not followed with scanning off");

    a_scan_hold_idle: assert property (
        (scan_inputs_enable_i && !take && scan_mask[conv_channel_o]) |=> $stable(conv_channel_o)
    ) else $error("scan channel moved without a result");

    a_dma_ptr_zero: assert property (
        (take && is_dma) |=> (buf_ptr_o == '0)
    ) else $error("buffer pointer moved in DMA mode");

    a_dma_req_only: assert property (
        !(take && is_dma) |=> !dma_req_o
    ) else $error("DMA request without a result in buffer zero");

    a_dma_other_buf: assert property (
        (take && is_dma) |=> (buf_r[1] == $past(buf_r[1]))
    ) else $error("DMA result written outside buffer zero");

    a_ptr_hold_idle: assert property (
        !take |=> $stable(buf_ptr_o)
    ) else $error("buffer pointer moved without a result");

    a_ptr_hold_frozen: assert property (
        buf_freeze_i |=> $stable(buf_ptr_o)
    ) else $error("buffer pointer moved while frozen");

    a_seq_buf_keep: assert property (
        (take && !is_dma && (buf_ptr_o != '0)) |=> (buf_r[0] == $past(buf_r[0]))
    ) else $error("result written away from its sequence position");

    a_done_sw_clear: assert property (
        (done_clear_i && !conv_done_i) |=> !conv_done_flag_o
    ) else $error("done flag not cleared by software");

    a_done_only_set: assert property (
        (!conv_done_flag_o && !conv_done_i) |=> !conv_done_flag_o
    ) else $error("done flag set without a completion");

    a_opamp_release: assert property (
        !opamp2_enable_i |=> !mux_conflict_o && (opamp_pins_o == '0)
    ) else $error("op amp pins claimed while disabled");

    a_opamp_scan_skip: assert property (
        (opamp2_enable_i && scan_inputs_enable_i && (scan_mask != '0)) |=> (conv_channel_o >= `ARB_MUX_FIRST_FREE)
    ) else $error("scan picked an input claimed by the op amp");

    a_count_step: assert property (
        (take && !irq_point) |=> (cnt_r == $past(cnt_r) + `ARB_SMPI_W'(1))
    ) else $error("sample count did not step");

    a_count_hold: assert property (
        !take |=> $stable(cnt_r)
    ) else $error("sample count moved without a result");

    c_buffered_irq: cover property (irq_point && !is_dma && irq_enable_i);
    c_dma_advance: cover property (dma_adv);
    c_fifo_full: cover property (!conv_ready_o);
    c_scan_restart: cover property (irq_point && scan_inputs_enable_i && (scan_mask != '0));
    c_opamp_conflict: cover property (opamp2_enable_i && mux_conflict_o);
endmodule // arb_top

`default_nettype wire

// File: arb_regs.svh
/*
 * Fixed sizes, masks and counts of the converter result sequencer.
 * Assumes it is included by bare name from the package and modules of this block.
 */
`ifndef ARB_REGS_SVH
`define ARB_REGS_SVH

`define ARB_NUM_BUFS 16
`define ARB_BUF_W 4
`define ARB_DATA_W 12
`define ARB_NUM_CH 32
`define ARB_CH_W 5
`define ARB_SMPI_W 5
`define ARB_FIFO_DEPTH 4
`define ARB_DMA_AW 8
`define ARB_OPAMP_PIN_CNT 3
`define ARB_OPAMP2_PINS 32'h0000_0007
`define ARB_MUX_FIRST_FREE 5'h03

`endif

// File: arb_pkg.sv
/*
 * Types shared by the converter result sequencer modules.
 * Assumes arb_regs.svh is on the include path.
 */
`include "arb_regs.svh"

package arb_pkg;
    typedef logic [`ARB_CH_W-1:0] arb_ch_t;
    typedef logic [`ARB_DATA_W-1:0] arb_data_t;
    typedef enum logic {ARB_MODE_BUFFERED, ARB_MODE_DMA} arb_mode_e;
endpackage

// File: arb_fifo.sv
/*
 * Small synchronous FIFO with valid/ready on both sides and registered flags.
 * Assumes DEPTH is a power of two and a single clock with synchronous reset.
 */
`timescale 1ns/1ps
`default_nettype none

module arb_fifo #(
    parameter int W = 12,
    parameter int DEPTH = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    input wire logic [W-1:0] in_data_i,
    output var logic in_ready_o,
    output var logic out_valid_o,
    output logic [W-1:0] out_data_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_r;
    logic [AW-1:0] rd_r;
    logic [AW:0] cnt_r;
    logic [AW:0] cnt_nxt;
    wire push = in_valid_i & in_ready_o;
    wire pop = out_valid_o & out_ready_i;

    assign cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    assign out_data_o = mem_r[rd_r];

    // flags are registered so the ports never see a combinational path
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
            in_ready_o <= 1'b1;
            out_valid_o <= 1'b0;
        end else begin
            wr_r <= wr_r + AW'(push);
            rd_r <= rd_r + AW'(pop);
            cnt_r <= cnt_nxt;
            in_ready_o <= cnt_nxt != (AW+1)'(DEPTH);
            out_valid_o <= cnt_nxt != '0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_r[wr_r] <= in_data_i;
        end
    end
endmodule // arb_fifo

`default_nettype wire

// File: arb_scan.sv
/*
 * Channel scan selector: walks the set bits of the scan list in rising order.
 * Assumes restart and advance are one-cycle pulses from the sequencer.
 */
`timescale 1ns/1ps
`default_nettype none
`include "arb_regs.svh"

module arb_scan (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic enable_i,
    input wire logic [`ARB_NUM_CH-1:0] select_i,
    input wire arb_pkg::arb_ch_t manual_ch_i,
    input wire logic restart_i,
    input wire logic advance_i,
    output var arb_pkg::arb_ch_t channel_o
);
    import arb_pkg::*;

    function automatic logic [`ARB_CH_W:0] lowest(input logic [`ARB_NUM_CH-1:0] m);
        logic [`ARB_CH_W:0] r;
        r = '0;
        for (int i = `ARB_NUM_CH - 1; i >= 0; i--) begin
            if (m[i]) begin
                r = {1'b1, `ARB_CH_W'(i)};
            end
        end
        return r;
    endfunction

    wire [`ARB_NUM_CH-1:0] above_m = select_i & (({`ARB_NUM_CH{1'b1}} << channel_o) << 1);
    wire [`ARB_CH_W:0] first_w = lowest(select_i);
    wire [`ARB_CH_W:0] next_w = lowest(above_m);
    wire arb_ch_t wrap_ch = next_w[`ARB_CH_W] ? next_w[`ARB_CH_W-1:0] : first_w[`ARB_CH_W-1:0];
    // an empty list falls back to the manual selection rather than stalling on a dead channel
    // a channel off the list (the manual one when scanning starts) hands over to the first listed
    wire listed = select_i[channel_o];
    wire arb_ch_t channel_nxt = (!enable_i || !first_w[`ARB_CH_W]) ? manual_ch_i :
                                (restart_i || !listed) ? first_w[`ARB_CH_W-1:0] :
                                advance_i ? wrap_ch : channel_o;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            channel_o <= '0;
        end else begin
            channel_o <= channel_nxt;
        end
    end
endmodule // arb_scan

`default_nettype wire

// File: arb_reader.sv
/*
 * Reader model for the DMA controller or CPU that drains the result buffers.
 * Assumes rd_data_i shows the buffer picked by rd_index_o one edge earlier.
 */
`timescale 1ns/1ps
`default_nettype none

module arb_reader (
    input wire logic clk_i,
    input wire logic dma_mode_i,
    input wire logic dma_req_i,
    input wire logic [1:0] lag_i,
    input wire logic [3:0] cpu_index_i,
    input wire arb_pkg::arb_data_t rd_data_i,
    output logic [3:0] rd_index_o,
    output arb_pkg::arb_data_t last_o,
    output int taken_o
);
    import arb_pkg::*;
    logic [3:0] req_sh_r = 4'h0;
    // the dma side only ever reads buffer zero
    assign rd_index_o = dma_mode_i ? 4'h0 : cpu_index_i;
    // read data is registered, so the earliest fresh sample is one edge after the request;
    // lag models a slow reader; it must still finish before the next result lands
    wire logic hit = req_sh_r[lag_i];
    initial begin
        taken_o = 0;
        last_o = '0;
    end
    always @(posedge clk_i) begin
        req_sh_r <= {req_sh_r[2:0], dma_req_i};
        if (hit) begin
            last_o <= rd_data_i;
            taken_o <= taken_o + 1;
        end
    end
endmodule // arb_reader
`default_nettype wire

// File: tb_top.sv
/*
 * Self-checking bench for arb_top with the arb_reader partner on its read side.
 * Assumes inputs are driven at the falling edge and outputs settle after the rising edge.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import arb_pkg::*;
    logic mclk = 0, rst = 1, scan_en = 0, dma_en = 0, irq_en = 0, op2 = 0;
    logic c_start = 0, c_done = 0, d_clr = 0, f_clr = 0, freeze = 0;
    logic [4:0] smpi = 5'h00;
    logic [15:0] sel_lo = 16'h0000, sel_hi = 16'h0000;
    logic [3:0] cpu_idx = 4'h0, rd_idx, ptr;
    logic [1:0] lag = 2'h0;
    arb_ch_t alt = '0, chan;
    arb_data_t res = '0, rdata, last;
    logic rdy, done_f, irq_f, irq, dreq, conflict;
    logic [7:0] daddr;
    logic [2:0] pins;
    int taken, miscompares = 0, cmp_count = 0, cycles = 0, irqs = 0;

    always #20 mclk = ~mclk;

    arb_top #(.DMA_AW(8), .FIFO_DEPTH(4)) dut (.mclk_i(mclk), .rst_i(rst), .samples_per_irq_i(smpi),
        .scan_inputs_enable_i(scan_en), .scan_select_low_i(sel_lo), .scan_select_high_i(sel_hi),
        .conv_dma_enable_i(dma_en), .irq_enable_i(irq_en), .opamp2_enable_i(op2), .input_mux_alt_set_i(alt),
        .conv_start_i(c_start), .conv_done_i(c_done), .conv_result_i(res), .done_clear_i(d_clr),
        .irq_flag_clear_i(f_clr), .buf_freeze_i(freeze), .rd_index_i(rd_idx), .conv_ready_o(rdy),
        .conv_channel_o(chan), .conv_done_flag_o(done_f), .irq_flag_o(irq_f), .irq_o(irq), .rd_data_o(rdata),
        .buf_ptr_o(ptr), .dma_req_o(dreq), .dma_addr_o(daddr), .mux_conflict_o(conflict), .opamp_pins_o(pins));

    arb_reader reader (.clk_i(mclk), .dma_mode_i(dma_en), .dma_req_i(dreq), .lag_i(lag), .cpu_index_i(cpu_idx),
        .rd_data_i(rdata), .rd_index_o(rd_idx), .last_o(last), .taken_o(taken));

    task automatic give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (irq === 1'b1) irqs <= irqs + 1;
        if (cycles == 3000) begin
            miscompares = miscompares + 1;
            give_verdict();
        end
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %0h seen %0h", nm, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask

    task automatic reset_dut(input int n);
        rst = 1;
        tick(n);
        rst = 0;
        tick(1);
    endtask

    task automatic conv(input arb_data_t d);
        c_start = 1;
        tick(1);
        c_start = 0;
        c_done = 1;
        res = d;
        chk("done_flag", 0, done_f);
        tick(1);
        c_done = 0;
        chk("done_flag", 1, done_f);
        tick(1);
    endtask

    task automatic rd(input logic [3:0] i, input arb_data_t e);
        cpu_idx = i;
        tick(2);
        chk("rd_data", e, rdata);
    endtask

    initial begin
        reset_dut(6);
        chk("ready", 1, rdy);
        chk("ptr", 0, ptr);
        chk("pins", 0, pins);
        $display("test reset finished");
        // scan list holds channels 5, 9 and 20
        smpi = 5'h02;
        irq_en = 1;
        scan_en = 1;
        sel_lo = 16'h0220;
        sel_hi = 16'h0010;
        tick(2);
        chk("chan", 5, chan);
        for (int i = 0; i < 3; i++) begin
            conv(12'h100 + i);
            tick(2);
            chk("ptr", (i + 1) % 3, ptr);
            chk("irq_flag", i == 2, irq_f);
            chk("chan", (i == 0) ? 9 : (i == 1) ? 20 : 5, chan);
        end
        chk("irq_count", 1, irqs);
        for (int i = 0; i < 3; i++) rd(i, 12'h100 + i);
        f_clr = 1;
        d_clr = 1;
        tick(1);
        f_clr = 0;
        d_clr = 0;
        tick(1);
        chk("irq_flag", 0, irq_f);
        chk("done_flag", 0, done_f);
        irq_en = 0;
        for (int i = 0; i < 3; i++) conv(12'h200 + i);
        tick(2);
        chk("irq_flag", 1, irq_f);
        chk("irq_count", 1, irqs);
        $display("test count point finished");
        reset_dut(2);
        smpi = 5'h0F;
        scan_en = 0;
        for (int i = 0; i < 16; i++) begin
            conv(12'hA00 + i);
            tick(1);
            chk("ptr", (i + 1) % 16, ptr);
        end
        rd(4'hF, 12'hA0F);
        // freeze stalls draining so the fifo fills and refuses the fifth word
        freeze = 1;
        for (int i = 0; i < 5; i++) begin
            c_done = 1;
            res = 12'hC00 + i;
            tick(1);
        end
        c_done = 0;
        chk("ready", 0, rdy);
        freeze = 0;
        tick(5);
        chk("ready", 1, rdy);
        chk("ptr", 4, ptr);
        rd(4'h3, 12'hC03);
        $display("test buffers finished");
        reset_dut(2);
        dma_en = 1;
        smpi = 5'h03;
        for (int i = 0; i < 8; i++) conv(12'hD00 + i);
        tick(3);
        chk("dma_addr", 2, daddr);
        chk("ptr", 0, ptr);
        chk("taken", 8, taken);
        chk("last", 12'hD07, last);
        smpi = 5'h1F;
        lag = 2'h1;
        for (int i = 0; i < 31; i++) conv(12'hE00 + i);
        tick(3);
        chk("dma_addr", 2, daddr);
        conv(12'hE1F);
        tick(3);
        chk("dma_addr", 3, daddr);
        chk("taken", 40, taken);
        chk("last", 12'hE1F, last);
        $display("test dma finished");
        reset_dut(2);
        dma_en = 0;
        op2 = 1;
        alt = 5'h01;
        sel_lo = 16'h0042;
        sel_hi = 16'h0000;
        tick(3);
        chk("conflict", 1, conflict);
        chk("pins", 3'h7, pins);
        scan_en = 1;
        alt = 5'h03;
        tick(3);
        chk("conflict", 0, conflict);
        chk("chan", 6, chan);
        $display("test op amp finished");
        give_verdict();
    end
endmodule // tb_top
`default_nettype wire
